// File: design/crc_engine_cfg.svh
// Register map, field positions, reset values and widths of the checksum engine.
`ifndef CRC_ENGINE_CFG_SVH
`define CRC_ENGINE_CFG_SVH

`define CRC_ADR_DATA       8'h00
`define CRC_ADR_POLY       8'h04
`define CRC_ADR_SEED       8'h08
`define CRC_ADR_CTRL       8'h0C
`define CRC_ADR_STATUS     8'h10
`define CRC_ADR_COUNT      8'h14

`define CRC_CTRL_WIDTH     0
`define CRC_CTRL_IN_REV    1
`define CRC_CTRL_OUT_REV   2
`define CRC_CTRL_INVERT    3
`define CRC_CTRL_RESULT    4
`define CRC_CTRL_BITS      5

`define CRC_STAT_BUSY      0
`define CRC_STAT_LEVEL     1

`define CRC_POLY_RESET     32'h0000_1021
`define CRC_SEED_RESET     32'h0000_FFFF
`define CRC_CTRL_RESET     5'h00
`define CRC_LOW_MASK       32'h0000_FFFF
`define CRC_ALL_ONES       32'hFFFF_FFFF

`define CRC_TOP_16         15
`define CRC_TOP_32         31
`define CRC_HALF_BITS      16
`define CRC_BYTE_BITS      8
`define CRC_LANES          4
`define CRC_ADR_BITS       8

`endif

// File: design/crc_engine_pkg.sv
// Types used by the checksum engine; its byte buffer uses none of them.
package crc_engine_pkg;

	typedef enum logic {
		width_16,
		width_32
	} width_select_e;

	typedef enum logic {
		final_result_option,
		raw_result_option
	} result_kind_e;

	typedef enum logic {
		st_idle,
		st_fold
	} fold_state_e;

endpackage

// File: design/crc_fold_buffer.sv
// Small flip-flop queue with valid and ready on both sides.
`timescale 1ns/1ps
module crc_fold_buffer #(
	parameter int WIDTH = 70,
	parameter int DEPTH = 2,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [CW-1:0]    level
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic             push;
	logic             pop;

	assign in_ready  = (level != FULL);
	assign out_valid = (level != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = store[rd_ptr];

	always_ff @(posedge clk) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + PW'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + PW'(1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level <= '0;
		end else if (push && !pop) begin
			level <= level + CW'(1);
		end else if (pop && !push) begin
			level <= level - CW'(1);
		end
	end

endmodule

// File: design/programmable_crc_engine.sv
// Programmable 16/32-bit checksum engine behind a classic Wishbone slave.
//
// Summary of operation
// - Computes a checksum of sixteen or thirty-two bits, chosen by software.
// - Polynomial, seed and all protocol options are writable registers.
// - The loaded seed is the current checksum; every data byte folds into it.
// - Loading a previously read raw checksum as seed resumes exactly.
// - Data writes of 32 or 8 bits fold exactly the bytes their lanes carry.
// - Result depends only on the byte sequence, never on write chunking.
// - Reading the data register returns the checksum and leaves it intact.
// - A control bit selects final or raw checksum on data register reads.
// - Full reconfiguration is allowed at any time without a reset.
// - Each data word is folded with the configuration in force when written.
// - Reset default is 16-bit, polynomial 0x1021, seed all ones, no options.
// - Writing the seed starts a new computation under the current configuration.
// - Final result applies output reflection and complement; raw is unmodified.
// - Polynomial is held most significant bit first without the top term.
// - Input reflection, output reflection and complement are separate controls.
//
// Implementation choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "crc_engine_cfg.svh"
module programmable_crc_engine #(
	parameter int BUF_DEPTH = 2
) (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [`CRC_ADR_BITS-1:0]  wb_adr_i,
	input  wire logic [`CRC_LANES-1:0]     wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o
);
	localparam int ENTRY_W = 32 + `CRC_LANES + 32 + 2;
	localparam int LW      = $clog2(BUF_DEPTH + 1);

	// Configuration, checksum and byte count registers.
	logic [31:0]              poly;
	logic [31:0]              seed;
	logic [`CRC_CTRL_BITS-1:0] ctrl;
	logic [31:0]              crc;
	logic [31:0]              byte_count;

	// Bus decode.
	logic                     req;
	logic                     take;
	logic                     stall;
	logic                     hit_data;
	logic                     hit_poly;
	logic                     hit_seed;
	logic                     hit_ctrl;
	logic                     hit_status;
	logic                     hit_count;
	logic                     data_push;
	logic                     seed_load;
	logic [31:0]              lane_mask;
	logic [31:0]              next_poly;
	logic [31:0]              next_seed;
	logic [31:0]              next_rdata;

	// Buffer and folding engine.
	logic [ENTRY_W-1:0]       buf_in;
	logic [ENTRY_W-1:0]       buf_out;
	logic                     buf_in_ready;
	logic                     buf_out_valid;
	logic                     buf_out_ready;
	logic [LW-1:0]            buf_level;
	crc_engine_pkg::fold_state_e state;
	logic [31:0]              cur_data;
	logic [`CRC_LANES-1:0]    cur_mask;
	logic [31:0]              cur_poly;
	logic                     cur_wide;
	logic                     cur_in_rev;
	logic [1:0]               lane;
	logic [`CRC_BYTE_BITS-1:0] lane_byte;
	logic [`CRC_BYTE_BITS-1:0] fold_in;
	logic [`CRC_LANES-1:0]    next_mask;
	logic                     folding;
	logic                     engine_idle;
	logic [31:0]              result_view;

	// Folds one byte, most significant bit first, into a register of either width.
	function automatic logic [31:0] fold_byte(
		input logic [31:0]               c_in,
		input logic [31:0]               p,
		input logic [`CRC_BYTE_BITS-1:0] d,
		input logic                      wide
	);
		logic [31:0] c;
		logic        fb;
		c = c_in;
		fb = 1'b0;
		for (int i = 0; i < `CRC_BYTE_BITS; i++) begin
			if (wide) begin
				fb = c[`CRC_TOP_32] ^ d[`CRC_BYTE_BITS - 1 - i];
				c = {c[30:0], 1'b0};
				c = fb ? (c ^ p) : c;
			end else begin
				fb = c[`CRC_TOP_16] ^ d[`CRC_BYTE_BITS - 1 - i];
				c = {c[30:0], 1'b0} & `CRC_LOW_MASK;
				c = fb ? (c ^ (p & `CRC_LOW_MASK)) : c;
			end
		end
		return c;
	endfunction

	function automatic logic [`CRC_BYTE_BITS-1:0] rev_byte(
		input logic [`CRC_BYTE_BITS-1:0] d
	);
		logic [`CRC_BYTE_BITS-1:0] r;
		r = '0;
		for (int i = 0; i < `CRC_BYTE_BITS; i++) begin
			r[i] = d[`CRC_BYTE_BITS - 1 - i];
		end
		return r;
	endfunction

	// Reverses the checksum over its active width only.
	function automatic logic [31:0] rev_width(
		input logic [31:0] c,
		input logic        wide
	);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < 32; i++) begin
			if (wide) begin
				r[i] = c[`CRC_TOP_32 - i];
			end else if (i < `CRC_HALF_BITS) begin
				r[i] = c[`CRC_TOP_16 - i];
			end
		end
		return r;
	endfunction

	assign req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign hit_data   = (wb_adr_i == `CRC_ADR_DATA);
	assign hit_poly   = (wb_adr_i == `CRC_ADR_POLY);
	assign hit_seed   = (wb_adr_i == `CRC_ADR_SEED);
	assign hit_ctrl   = (wb_adr_i == `CRC_ADR_CTRL);
	assign hit_status = (wb_adr_i == `CRC_ADR_STATUS);
	assign hit_count  = (wb_adr_i == `CRC_ADR_COUNT);
	assign data_push  = req & wb_we_i & hit_data;
	assign engine_idle = ~buf_out_valid & (state == crc_engine_pkg::st_idle);

	// A data write waits for room in the buffer; a seed write or a data, seed or count
	// read waits until every queued byte is folded, so ordering with data is kept.
	// Status reads never wait, so software can poll them.
	always_comb begin
		if (data_push) begin
			stall = ~buf_in_ready;
		end else if (hit_data || hit_seed || hit_count) begin
			stall = ~engine_idle;
		end else begin
			stall = 1'b0;
		end
	end

	assign take      = req & ~stall;
	assign seed_load = take & wb_we_i & hit_seed;

	generate
		for (genvar g = 0; g < `CRC_LANES; g++) begin : g_lane
			assign lane_mask[g*`CRC_BYTE_BITS +: `CRC_BYTE_BITS] =
				{`CRC_BYTE_BITS{wb_sel_i[g]}};
		end
	endgenerate

	assign next_poly = (poly & ~lane_mask) | (wb_dat_i & lane_mask);
	assign next_seed = (seed & ~lane_mask) | (wb_dat_i & lane_mask);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= take;
		end
	end

	// Polynomial register
	// The polynomial is stored as written; bit n is the coefficient of x^n.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			poly <= `CRC_POLY_RESET;
		end else if (take && wb_we_i && hit_poly) begin
			poly <= next_poly;
		end
	end

	// Reconfiguration anytime
	// Control changes take effect at once for later writes; queued words keep
	// the copy taken when they were written.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= `CRC_CTRL_RESET;
		end else if (take && wb_we_i && hit_ctrl && wb_sel_i[0]) begin
			ctrl <= wb_dat_i[`CRC_CTRL_BITS-1:0];
		end
	end

	// Default protocol
	// Seed resets to all ones in 16-bit form, matching the reset checksum.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seed <= `CRC_SEED_RESET;
		end else if (seed_load) begin
			seed <= next_seed;
		end
	end

	// Configuration snapshot
	// Width, input reflection and polynomial travel with each data word.
	assign buf_in = {ctrl[`CRC_CTRL_IN_REV], ctrl[`CRC_CTRL_WIDTH], poly,
		wb_sel_i, wb_dat_i};

	crc_fold_buffer #(
		.WIDTH (ENTRY_W),
		.DEPTH (BUF_DEPTH),
		.CW    (LW)
	) u_buffer (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (data_push),
		.in_data   (buf_in),
		.in_ready  (buf_in_ready),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out),
		.level     (buf_level)
	);

	assign buf_out_ready = (state == crc_engine_pkg::st_idle);
	assign folding       = (state == crc_engine_pkg::st_fold) && (cur_mask != '0);

	// Lane order
	// Lanes fold from the lowest address upward, so a word equals its four
	// bytes written one at a time.
	always_comb begin
		lane = 2'h0;
		for (int i = `CRC_LANES - 1; i >= 0; i--) begin
			if (cur_mask[i]) begin
				lane = 2'(i);
			end
		end
	end

	always_comb begin
		next_mask = cur_mask;
		next_mask[lane] = 1'b0;
	end

	assign lane_byte = cur_data[lane*`CRC_BYTE_BITS +: `CRC_BYTE_BITS];

	// Input reflection
	// Reflected input is folded most significant bit first after reversal; the
	// matching output reversal restores the reflected algorithm's value.
	assign fold_in = cur_in_rev ? rev_byte(lane_byte) : lane_byte;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= crc_engine_pkg::st_idle;
		end else begin
			unique case (state)
				crc_engine_pkg::st_idle: begin
					if (buf_out_valid) begin
						state <= crc_engine_pkg::st_fold;
					end
				end
				crc_engine_pkg::st_fold: begin
					if (next_mask == '0 || cur_mask == '0) begin
						state <= crc_engine_pkg::st_idle;
					end
				end
			endcase
		end
	end

	// Byte lanes
	// Only lanes whose select bit was set are folded, one per clock.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_mask <= '0;
		end else if (buf_out_valid && buf_out_ready) begin
			cur_mask <= buf_out[32 +: `CRC_LANES];
		end else if (folding) begin
			cur_mask <= next_mask;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_data   <= '0;
			cur_poly   <= '0;
			cur_wide   <= 1'b0;
			cur_in_rev <= 1'b0;
		end else if (buf_out_valid && buf_out_ready) begin
			cur_data   <= buf_out[31:0];
			cur_poly   <= buf_out[32 + `CRC_LANES +: 32];
			cur_wide   <= buf_out[ENTRY_W - 2];
			cur_in_rev <= buf_out[ENTRY_W - 1];
		end
	end

	// Resume from raw
	// A seed write only lands once the engine is idle, so it never races a fold.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			crc <= `CRC_SEED_RESET;
		end else if (seed_load) begin
			crc <= ctrl[`CRC_CTRL_WIDTH] ? next_seed : (next_seed & `CRC_LOW_MASK);
		end else if (folding) begin
			crc <= fold_byte(crc, cur_poly, fold_in, cur_wide);
		end
	end

	// Bytes folded since the last seed load, for software progress checks.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			byte_count <= '0;
		end else if (seed_load) begin
			byte_count <= '0;
		end else if (folding) begin
			byte_count <= byte_count + 32'h0000_0001;
		end
	end

	always_comb begin
		result_view = ctrl[`CRC_CTRL_WIDTH] ? crc : (crc & `CRC_LOW_MASK);
		if (ctrl[`CRC_CTRL_RESULT] == crc_engine_pkg::final_result_option) begin
			if (ctrl[`CRC_CTRL_OUT_REV]) begin
				result_view = rev_width(crc, ctrl[`CRC_CTRL_WIDTH]);
			end
			if (ctrl[`CRC_CTRL_INVERT]) begin
				result_view = result_view ^ (ctrl[`CRC_CTRL_WIDTH] ? `CRC_ALL_ONES
					: `CRC_LOW_MASK);
			end
		end
	end

	always_comb begin
		next_rdata = '0;
		if (hit_data) begin
			next_rdata = result_view;
		end else if (hit_poly) begin
			next_rdata = poly;
		end else if (hit_seed) begin
			next_rdata = seed;
		end else if (hit_ctrl) begin
			next_rdata[`CRC_CTRL_BITS-1:0] = ctrl;
		end else if (hit_status) begin
			next_rdata[`CRC_STAT_BUSY] = ~engine_idle;
			next_rdata[`CRC_STAT_LEVEL +: LW] = buf_level;
		end else if (hit_count) begin
			next_rdata = byte_count;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= '0;
		end else if (take && !wb_we_i) begin
			wb_dat_o <= next_rdata;
		end
	end

endmodule

// File: verification/crc_engine_chk.sv
// Assertions on the bus ports of the checksum engine.
`timescale 1ns/1ps
`include "crc_engine_cfg.svh"
module crc_engine_chk (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o
);
	logic        dirty;
	logic        wide;
	logic        held;
	logic [31:0] last;
	logic [31:0] poly;
	wire rd_ack = wb_ack_o && !wb_we_i;
	wire wr_ack = wb_ack_o && wb_we_i;
	wire rd_dat = rd_ack && wb_adr_i == `CRC_ADR_DATA;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dirty <= 1'b0;
			wide <= 1'b0;
			poly <= 32'h00001021;
		end else if (wr_ack) begin
			dirty <= 1'b1;
			if (wb_adr_i == `CRC_ADR_CTRL && wb_sel_i[0])
				wide <= wb_dat_i[0];
			for (int i = 0; i < 4; i++)
				if (wb_adr_i == `CRC_ADR_POLY && wb_sel_i[i])
					poly[8*i+:8] <= wb_dat_i[8*i+:8];
		end
	end
	// A data read twice with no write between must not move.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			held <= 1'b0;
			last <= 32'h0;
		end else if (rd_dat) begin
			held <= 1'b1;
			last <= wb_dat_o;
		end else if (wr_ack) begin
			held <= 1'b0;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		##[1:40] wb_ack_o;
	endsequence
	property p_ack_bound; s_req |-> s_ans; endproperty
	a_ack_bound: assert property (p_ack_bound) else $error("no ack");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
	property p_dat_hold; $changed(wb_dat_o) |-> rd_ack; endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("data moved");
	property p_read_same; rd_dat && held |-> wb_dat_o == last; endproperty
	a_read_same: assert property (p_read_same) else $error("read moved");
	property p_reset_data; rd_dat && !dirty |-> wb_dat_o == 32'h0000FFFF; endproperty
	a_reset_data: assert property (p_reset_data) else $error("bad seed");
	property p_reset_ctrl;
		rd_ack && wb_adr_i == `CRC_ADR_CTRL && !dirty |-> wb_dat_o == 32'h0;
	endproperty
	a_reset_ctrl: assert property (p_reset_ctrl) else $error("bad ctrl");
	property p_poly; rd_ack && wb_adr_i == `CRC_ADR_POLY |-> wb_dat_o == poly; endproperty
	a_poly: assert property (p_poly) else $error("bad poly");
	property p_narrow; rd_dat && !wide |-> wb_dat_o[31:16] == 16'h0; endproperty
	a_narrow: assert property (p_narrow) else $error("high half set");
endmodule
bind programmable_crc_engine crc_engine_chk chk (
	.clk      (clk),
	.rst      (rst),
	.wb_cyc_i (wb_cyc_i),
	.wb_stb_i (wb_stb_i),
	.wb_we_i  (wb_we_i),
	.wb_adr_i (wb_adr_i),
	.wb_sel_i (wb_sel_i),
	.wb_dat_i (wb_dat_i),
	.wb_dat_o (wb_dat_o),
	.wb_ack_o (wb_ack_o)
);

// File: verification/crc_host.sv
// Host model issuing classic Wishbone single cycles.
`timescale 1ns/1ps
module crc_host (
	input  wire logic        clk,
	input  wire logic        ack,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      dat
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
endmodule

// File: verification/tb_top.sv
// Bench: protocol check values, resume, reconfiguration and random traffic.
`timescale 1ns/1ps
`include "crc_engine_cfg.svh"
module tb_top;
	logic        clk;
	logic        rst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat;
	logic [31:0] rdat;
	logic        ack;
	int          errors;
	int          checks_done;
	logic [31:0] exp_q[$];
	logic [31:0] raw;
	logic [31:0] poly;
	logic [4:0]  ctrl;
	logic [31:0] lfsr;
	logic [31:0] keep;
	logic [31:0] tp[3] = '{32'h00001021, 32'h00008005, 32'h04C11DB7};
	logic [31:0] ts[3] = '{32'h0000FFFF, 32'h00000000, 32'hFFFFFFFF};
	logic [31:0] tk[3] = '{32'h000029B1, 32'h0000BB3D, 32'hCBF43926};
	logic [4:0]  tc[3] = '{5'h00, 5'h06, 5'h0F};
	int          tstep[3] = '{4, 1, 2};

	programmable_crc_engine dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack));
	crc_host host (.clk(clk), .ack(ack), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.sel(sel), .dat(dat));

	function automatic logic [31:0] rev(logic [31:0] v, int n);
		logic [31:0] r;
		r = 32'h0;
		for (int i = 0; i < n; i++) r[i] = v[n-1-i];
		return r;
	endfunction
	function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] b);
		logic top;
		if (ctrl[1]) b = 8'(rev(32'(b), 8));
		c = c ^ (ctrl[0] ? {b, 24'h0} : {16'h0, b, 8'h0});
		for (int i = 0; i < 8; i++) begin
			top = ctrl[0] ? c[31] : c[15];
			c = c << 1;
			if (top) c = c ^ poly;
		end
		return ctrl[0] ? c : c & 32'h0000FFFF;
	endfunction
	function automatic logic [31:0] view();
		logic [31:0] v;
		v = ctrl[2] ? rev(raw, ctrl[0] ? 32 : 16) : raw;
		if (ctrl[3]) v = v ^ (ctrl[0] ? 32'hFFFFFFFF : 32'h0000FFFF);
		return ctrl[4] ? raw : v;
	endfunction
	function automatic logic [31:0] step(logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h00400007 : 32'h0);
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic complete_run();
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		exp_q.push_back(want);
		host.xfer(1'b0, a, 4'hF, 32'h0);
	endtask
	task automatic feed(input logic [31:0] w, input logic [3:0] s);
		for (int i = 0; i < 4; i++) if (s[i]) raw = fold(raw, w[8*i+:8]);
		host.xfer(1'b1, `CRC_ADR_DATA, s, w);
	endtask
	task automatic setup(input logic [31:0] p, input logic [4:0] c, input logic [31:0] s);
		host.xfer(1'b1, `CRC_ADR_POLY, 4'hF, p);
		host.xfer(1'b1, `CRC_ADR_CTRL, 4'hF, {27'h0, c});
		host.xfer(1'b1, `CRC_ADR_SEED, 4'hF, s);
		poly = p;
		ctrl = c;
		raw = c[0] ? s : s & 32'h0000FFFF;
	endtask
	// Bytes sit on their natural lane, so chunks mix whole words, partial words and lone bytes.
	task automatic msg(input int first, input int last, input int n);
		logic [31:0] w;
		logic [3:0]  s;
		w = 32'h0;
		s = 4'h0;
		for (int i = first; i <= last; i++) begin
			w[8*(i%4)+:8] = 8'h30 + 8'(i);
			s[i%4] = 1'b1;
			if (i % 4 == 3 || i == last || (i + 1) % n == 0) begin
				feed(w, s);
				w = 32'h0;
				s = 4'h0;
			end
		end
	endtask

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
			check(rdat, exp_q.pop_front());
		end
	end
	initial begin
		repeat (30000) @(posedge clk);
		errors++;
		complete_run();
	end
	initial begin
		errors = 0;
		checks_done = 0;
		lfsr = 32'h00001C3C;
		raw = 32'h0000FFFF;
		poly = 32'h00001021;
		ctrl = 5'h00;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(`CRC_ADR_DATA, 32'h0000FFFF);
		rd(`CRC_ADR_CTRL, 32'h0);
		rd(`CRC_ADR_POLY, 32'h00001021);
		rd(8'h20, 32'h0);
		feed(32'h34333231, 4'hF);
		rd(`CRC_ADR_STATUS, 32'h00000001);
		rd(`CRC_ADR_COUNT, 32'h00000004);
		rd(`CRC_ADR_DATA, view());
		for (int k = 0; k < 3; k++) begin
			setup(tp[k], tc[k], ts[k]);
			msg(1, 9, tstep[k]);
			rd(`CRC_ADR_DATA, tk[k]);
			rd(`CRC_ADR_COUNT, 32'h00000009);
			rd(`CRC_ADR_STATUS, 32'h00000000);
			rd(`CRC_ADR_DATA, view());
			ctrl[4] = 1'b1;
			host.xfer(1'b1, `CRC_ADR_CTRL, 4'hF, {27'h0, ctrl});
			rd(`CRC_ADR_DATA, raw);
		end
		setup(32'h04C11DB7, 5'h1F, 32'hFFFFFFFF);
		msg(1, 4, 4);
		rd(`CRC_ADR_DATA, raw);
		keep = raw;
		setup(32'h00001021, 5'h00, 32'h0000FFFF);
		msg(1, 9, 3);
		rd(`CRC_ADR_DATA, 32'h000029B1);
		setup(32'h04C11DB7, 5'h0F, keep);
		msg(5, 9, 1);
		rd(`CRC_ADR_DATA, 32'hCBF43926);
		repeat (3) begin
			lfsr = step(lfsr);
			keep = step(lfsr);
			setup(lfsr, lfsr[4:0], keep);
			repeat (12) begin
				lfsr = step(lfsr);
				feed(lfsr, lfsr[31:28]);
			end
			rd(`CRC_ADR_POLY, poly);
			rd(`CRC_ADR_DATA, view());
		end
		wait (exp_q.size() == 0);
		complete_run();
	end
endmodule
